// *** include/pbm_pkg.sv ***
// Package with constants and types for the BAR and VF function map
package pbm_pkg;
    localparam int NUM_BARS = 6;
    localparam int RP_BARS = 2;
    localparam int ADDR_W = 64;
    localparam int MAX_PFS = 4;
    localparam int VF_CNT_W = 8;
    localparam logic [8:0] TOTAL_VF_MAX = 9'h0fc;
    localparam logic [9:0] FUNC_SPACE = 10'h100;
    localparam logic [7:0] GAP_ARI_SMALL = 8'h04;
    localparam logic [7:0] GAP_ARI_LARGE = 8'h40;
    localparam logic [7:0] GAP_NON_ARI = 8'h01;
    localparam logic [7:0] NON_ARI_VFS = 8'h07;
    localparam logic [7:0] PF0_FUNC_NUM = 8'h00;
    localparam logic [7:0] PF1_FUNC_NUM = 8'h01;
    localparam logic [7:0] VF_BASE_NUM = 8'h40;
    localparam logic [15:0] MBOX_BASE = 16'h2400;
    localparam logic [5:0] MIN_APER_LOG2 = 6'h07;
    localparam logic [5:0] MAX32_APER_LOG2 = 6'h1f;
    localparam logic [5:0] MAX64_APER_LOG2 = 6'h3f;
    localparam logic [5:0] PAGE_SHIFT = 6'h0c;

    // Where a BAR hit is sent
    typedef enum logic [2:0]
    {
        PBM_TGT_NONE,
        PBM_TGT_DMA,
        PBM_TGT_MBOX,
        PBM_TGT_LITE,
        PBM_TGT_BRIDGE
    } pbm_target_t;

    // Log2 of an aperture size, clamped between MIN_APER_LOG2 and the 32-bit or 64-bit maximum
    function automatic logic [5:0] pbm_clamp_log2(input logic [5:0] req, input logic is64);
        logic [5:0] hi;
        hi = is64 ? MAX64_APER_LOG2 : MAX32_APER_LOG2;
        if (req < MIN_APER_LOG2)
            return MIN_APER_LOG2;
        else if (req > hi)
            return hi;
        else
            return req;
    endfunction : pbm_clamp_log2

    // Mask of address bits compared against the base
    function automatic logic [ADDR_W-1:0] pbm_aper_mask(input logic [5:0] lg);
        return ~((64'h1 << lg) - 64'h1);
    endfunction : pbm_aper_mask
endpackage : pbm_pkg

// *** include/pbm_bar_if.sv ***
// Interface carrying one BAR's configuration and decode answer
`timescale 1ns/1ps
`default_nettype none
interface pbm_bar_if;
    import pbm_pkg::*;
    logic [pbm_pkg::ADDR_W-1:0] base;
    logic [5:0] size_log2;
    logic is64;
    logic usable;
    logic hit;
    modport cfg (output base, output size_log2, output is64, output usable, input hit);
    modport dec (input base, input size_log2, input is64, input usable, output hit);
endinterface : pbm_bar_if
`default_nettype wire

// *** core/pbm_bar_match.sv ***
// Masked address compare for one BAR window
`timescale 1ns/1ps
`default_nettype none
module pbm_bar_match
    import pbm_pkg::*;
(
    // Request address
    input wire logic [ADDR_W-1:0] addr,
    // BAR configuration and hit
    pbm_bar_if.dec bar
);
    wire logic [5:0] lg;
    wire logic [ADDR_W-1:0] msk;
    wire logic [ADDR_W-1:0] ext_addr;
    wire logic [ADDR_W-1:0] ext_base;

    // 32-bit BARs only match addresses whose upper half is zero
    assign lg = pbm_clamp_log2(bar.size_log2, bar.is64);
    assign msk = pbm_aper_mask(lg);
    assign ext_addr = bar.is64 ? addr : {32'h0, addr[31:0]};
    assign ext_base = bar.is64 ? bar.base : {32'h0, bar.base[31:0]};
    assign bar.hit = bar.usable && ((ext_addr & msk) == (ext_base & msk)) && (bar.is64 || addr[63:32] == 32'h0);
endmodule : pbm_bar_match
`default_nettype wire

// *** core/pbm_function_map.sv ***
// BAR routing and SR-IOV function map for the endpoint
`timescale 1ns/1ps
`default_nettype none
module pbm_function_map
    import pbm_pkg::*;
#(
    parameter int NB = NUM_BARS,
    parameter int NPF = MAX_PFS
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Mode and BAR configuration
    input wire logic root_port_mode,
    input wire logic [NB-1:0] bar_enable,
    input wire logic [NB-1:0] bar_is64,
    input wire logic [NB-1:0] bar_to_bridge,
    input wire logic bar0_mailbox,
    input wire logic [NB*6-1:0] bar_size_log2,
    input wire logic [NB*ADDR_W-1:0] bar_base,
    input wire logic [NB*ADDR_W-1:0] bar_xlate,
    // Host request
    input wire logic req_valid,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic req_is_dma,
    // Routed request
    output logic route_valid,
    output logic [2:0] route_target,
    output logic [2:0] route_bar,
    output logic [ADDR_W-1:0] route_axi_addr,
    output logic route_unsupported,
    output logic route_rejected,
    // SR-IOV configuration
    input wire logic ari_enable,
    input wire logic gap_sel_large,
    input wire logic [NPF*VF_CNT_W-1:0] pf_vf_count,
    input wire logic [NPF*4-1:0] pf_cap_version,
    input wire logic [NPF*16-1:0] pf_dep_link,
    input wire logic [NPF*16-1:0] pf_vf_dev_id,
    input wire logic [NPF*32-1:0] pf_page_sizes,
    input wire logic [NPF-1:0] vf_enable_wr,
    input wire logic [NPF-1:0] vf_enable_val,
    // SR-IOV capability fields as seen by the host
    output logic [7:0] general_first_vf_gap,
    output logic [NPF*8-1:0] per_pf_first_vf_gap,
    output logic [NPF*8-1:0] per_pf_total_vfs,
    output logic [NPF*4-1:0] per_pf_cap_version,
    output logic [NPF*16-1:0] per_pf_dep_link,
    output logic [NPF*16-1:0] per_pf_vf_dev_id,
    output logic [NPF*32-1:0] per_pf_page_sizes,
    output logic [NPF-1:0] vf_active,
    output logic vf_config_error
);
    wire logic [NB-1:0] hit_w;
    wire logic [NB-1:0] usable_w;
    wire logic [NB-1:0] odd64_w;
    logic [NB-1:0] shadowed;
    pbm_bar_if bif [NB] ();

    // A 64-bit BAR hides its upper neighbour
    always_comb
    begin
        shadowed = '0;
        for (int i = 0; i < NB - 1; i++)
            if (bar_enable[i] && bar_is64[i])
                shadowed[i+1] = 1'b1;
    end

    // Usable windows, limited by mode and enables
    genvar g;
    generate
        for (g = 0; g < NB; g++)
        begin : g_bar
            // An odd BAR is only ever an upper half, so a 64-bit flag on it disables it
            assign odd64_w[g] = (g % 2 == 1) && bar_is64[g];
            assign usable_w[g] = bar_enable[g] && !shadowed[g]
                && (!root_port_mode || g < RP_BARS)
                && !odd64_w[g];
            assign bif[g].base = bar_base[g*ADDR_W +: ADDR_W];
            assign bif[g].size_log2 = bar_size_log2[g*6 +: 6];
            assign bif[g].is64 = bar_is64[g] && (g + 1 < NB);
            assign bif[g].usable = usable_w[g];
            assign hit_w[g] = bif[g].hit;
            pbm_bar_match u_match
            (
                .addr(req_addr),
                .bar(bif[g])
            );
        end
    endgenerate

    // Odd BARs never open a 64-bit window of their own
    chk_odd_not64: assert property (@(posedge mclk) disable iff (!rstn)
        !(|(hit_w & odd64_w)))
        else $error("odd BAR decoded as a 64-bit window");

    // Lowest hitting BAR wins
    logic [2:0] sel_idx;
    logic sel_hit;
    always_comb
    begin
        sel_idx = 3'h0;
        sel_hit = 1'b0;
        for (int i = NB - 1; i >= 0; i--)
            if (hit_w[i])
            begin
                sel_idx = 3'(i);
                sel_hit = 1'b1;
            end
    end

    wire logic [5:0] sel_lg;
    wire logic [ADDR_W-1:0] sel_mask;
    wire logic [ADDR_W-1:0] sel_xlate;
    wire pbm_target_t sel_tgt;
    wire logic sel_reject;
    assign sel_lg = pbm_clamp_log2(bar_size_log2[sel_idx*6 +: 6], bar_is64[sel_idx]);
    assign sel_mask = pbm_aper_mask(sel_lg);
    assign sel_xlate = bar_xlate[sel_idx*ADDR_W +: ADDR_W];
    // Fixed targets for BAR1..2, configured for the rest
    assign sel_tgt = !sel_hit ? PBM_TGT_NONE
        : (sel_idx == 3'h0) ? (bar0_mailbox ? PBM_TGT_MBOX : PBM_TGT_DMA)
        : (sel_idx == 3'h1) ? PBM_TGT_LITE
        : (sel_idx == 3'h2) ? PBM_TGT_BRIDGE
        : (bar_to_bridge[sel_idx] ? PBM_TGT_BRIDGE : PBM_TGT_LITE);
    // Mailbox BAR refuses DMA and anything below the mailbox space
    assign sel_reject = (sel_tgt == PBM_TGT_MBOX) && (req_is_dma || ((req_addr & ~sel_mask) < 64'(MBOX_BASE)));

    // Fixed targets of the low BARs; lowest hit wins, so the lower bits must be clear
    // Overlapping windows are legal here, the priority keeps the answer unique
    chk_bar1_lite: assert property (@(posedge mclk) disable iff (!rstn)
        (req_valid && hit_w[1:0] == 2'h2) |=> (route_target == PBM_TGT_LITE && route_bar == 3'h1))
        else $error("BAR1 hit not routed to the lite master");
    chk_bar2_bridge: assert property (@(posedge mclk) disable iff (!rstn)
        (req_valid && hit_w[2:0] == 3'h4) |=> (route_target == PBM_TGT_BRIDGE && route_bar == 3'h2))
        else $error("BAR2 hit not routed to the bridge master");
    chk_mbox_low_refused: assert property (@(posedge mclk) disable iff (!rstn)
        (req_valid && hit_w[0] && bar0_mailbox && ((req_addr & ~sel_mask) < 64'(MBOX_BASE)))
        |=> (route_rejected && !route_valid))
        else $error("mailbox BAR forwarded an access below the mailbox space");

    // Registered routing result
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            route_valid <= 1'b0;
            route_target <= 3'h0;
            route_bar <= 3'h0;
            route_axi_addr <= '0;
            route_unsupported <= 1'b0;
            route_rejected <= 1'b0;
        end
        else
        begin
            route_valid <= req_valid && sel_hit && !sel_reject;
            route_target <= (req_valid && !sel_reject) ? sel_tgt : PBM_TGT_NONE;
            route_bar <= sel_idx;
            route_axi_addr <= (req_addr & ~sel_mask) | (sel_xlate & sel_mask);
            route_unsupported <= req_valid && !sel_hit;
            route_rejected <= req_valid && sel_reject;
        end
    end

    // Routing answer is one of forwarded, unsupported or rejected, never two
    chk_valid_exclusive: assert property (@(posedge mclk) disable iff (!rstn)
        route_valid |-> !(route_unsupported || route_rejected))
        else $error("routed request also flagged refused");
    chk_refused_no_target: assert property (@(posedge mclk) disable iff (!rstn)
        (route_unsupported || route_rejected) |-> (route_target == PBM_TGT_NONE && !route_valid))
        else $error("refused request still carries a target");
    chk_axi_offset_kept: assert property (@(posedge mclk) disable iff (!rstn)
        (req_valid && sel_hit) |=> (((route_axi_addr ^ $past(req_addr)) & ~$past(sel_mask)) == '0))
        else $error("translated address lost the window offset");
    chk_axi_base_xlated: assert property (@(posedge mclk) disable iff (!rstn)
        (req_valid && sel_hit) |=> (((route_axi_addr ^ $past(sel_xlate)) & $past(sel_mask)) == '0))
        else $error("translated address upper bits not taken from translation");

    // SR-IOV: total VF count and gap legality
    logic [9:0] vf_total;
    logic [7:0] pf0_cnt;
    always_comb
    begin
        vf_total = '0;
        for (int p = 0; p < NPF; p++)
            vf_total = vf_total + 10'(pf_vf_count[p*VF_CNT_W +: VF_CNT_W]);
    end
    assign pf0_cnt = pf_vf_count[0 +: VF_CNT_W];

    wire logic [7:0] gap_next;
    wire logic cfg_err_next;
    assign gap_next = !ari_enable ? GAP_NON_ARI
        : (gap_sel_large ? GAP_ARI_LARGE : GAP_ARI_SMALL);
    assign cfg_err_next = (vf_total > 10'(TOTAL_VF_MAX))
        || (ari_enable && (10'(gap_next) + vf_total > FUNC_SPACE))
        || (!ari_enable && (vf_total > 10'(NON_ARI_VFS) || pf_vf_count[VF_CNT_W +: VF_CNT_W*(NPF-1)] != '0));

    // Gap legality; the same error condition also keeps VF enables from taking effect
    chk_gap_ari_values: assert property (@(posedge mclk) disable iff (!rstn)
        ari_enable |=> (general_first_vf_gap == GAP_ARI_SMALL || general_first_vf_gap == GAP_ARI_LARGE))
        else $error("ARI first VF gap is neither of the two legal values");
    chk_func_space: assert property (@(posedge mclk) disable iff (!rstn)
        (ari_enable && (10'(gap_next) + vf_total > FUNC_SPACE)) |=> vf_config_error)
        else $error("gap plus VF total beyond function space not flagged");
    chk_non_ari_one_pf: assert property (@(posedge mclk) disable iff (!rstn)
        (!ari_enable && pf_vf_count[VF_CNT_W +: VF_CNT_W*(NPF-1)] != '0) |=> vf_config_error)
        else $error("non-ARI setup with VFs beyond the first PF not flagged");

    // Per-PF gap: VF_BASE_NUM plus the first PF's count for later PFs, minus PF0_FUNC_NUM for the first PF and PF1_FUNC_NUM for the rest
    function automatic logic [7:0] pf_gap(input int p, input logic [7:0] c0, input logic [7:0] cnt);
        logic [7:0] first_vf;
        first_vf = VF_BASE_NUM + ((p == 0) ? 8'h00 : c0);
        if (cnt == 8'h00)
            return 8'h00;
        return first_vf - ((p == 0) ? PF0_FUNC_NUM : PF1_FUNC_NUM);
    endfunction : pf_gap

    logic [NPF*8-1:0] pf_gap_next;
    always_comb
    begin
        pf_gap_next = '0;
        for (int p = 0; p < NPF; p++)
            pf_gap_next[p*8 +: 8] = pf_gap(p, pf0_cnt, 8'(pf_vf_count[p*VF_CNT_W +: VF_CNT_W]));
    end

    // First PF gap is fixed whenever it owns VFs, and zero otherwise
    chk_pf0_gap: assert property (@(posedge mclk) disable iff (!rstn)
        (pf_vf_count[0 +: VF_CNT_W] != '0) |=> (per_pf_first_vf_gap[7:0] == VF_BASE_NUM - PF0_FUNC_NUM))
        else $error("first PF first VF gap wrong");
    chk_no_vf_no_gap: assert property (@(posedge mclk) disable iff (!rstn)
        (pf_vf_count[0 +: VF_CNT_W] == '0) |=> (per_pf_first_vf_gap[7:0] == 8'h00))
        else $error("first PF without VFs reports a gap");

    // Capability fields registered for the host view
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            general_first_vf_gap <= 8'h00;
            per_pf_first_vf_gap <= '0;
            per_pf_total_vfs <= '0;
            per_pf_cap_version <= '0;
            per_pf_dep_link <= '0;
            per_pf_vf_dev_id <= '0;
            per_pf_page_sizes <= '0;
            vf_config_error <= 1'b0;
        end
        else
        begin
            general_first_vf_gap <= gap_next;
            per_pf_first_vf_gap <= pf_gap_next;
            for (int p = 0; p < NPF; p++)
                per_pf_total_vfs[p*8 +: 8] <= 8'(pf_vf_count[p*VF_CNT_W +: VF_CNT_W]);
            per_pf_cap_version <= pf_cap_version;
            per_pf_dep_link <= pf_dep_link;
            per_pf_vf_dev_id <= pf_vf_dev_id;
            per_pf_page_sizes <= pf_page_sizes;
            vf_config_error <= cfg_err_next;
        end
    end

    // Host view lags the settings by exactly one cycle
    chk_ids_copied: assert property (@(posedge mclk) disable iff (!rstn)
        1'b1 |=> (per_pf_cap_version == $past(pf_cap_version) && per_pf_vf_dev_id == $past(pf_vf_dev_id)))
        else $error("capability version or VF device id not reported");
    chk_pages_copied: assert property (@(posedge mclk) disable iff (!rstn)
        1'b1 |=> (per_pf_page_sizes == $past(pf_page_sizes) && per_pf_dep_link == $past(pf_dep_link)))
        else $error("page sizes or dependency link not reported");

    // VFs stay off from reset until software enables them
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            vf_active <= '0;
        else
            for (int p = 0; p < NPF; p++)
                if (vf_enable_wr[p])
                    vf_active[p] <= vf_enable_val[p] && (pf_vf_count[p*VF_CNT_W +: VF_CNT_W] != '0) && !cfg_err_next;
    end

    // Enables without VFs or with an illegal split leave the PF off
    chk_vf_needs_count: assert property (@(posedge mclk) disable iff (!rstn)
        (vf_enable_wr[NPF-1] && pf_vf_count[(NPF-1)*VF_CNT_W +: VF_CNT_W] == '0) |=> !vf_active[NPF-1])
        else $error("PF without VFs became active");
    chk_vf_bad_cfg_off: assert property (@(posedge mclk) disable iff (!rstn)
        (|vf_enable_wr && cfg_err_next) |=> ((vf_active & $past(vf_enable_wr)) == '0))
        else $error("VFs enabled under an illegal configuration");

    // Checks
    chk_unhit_flagged: assert property (@(posedge mclk) disable iff (!rstn)
        (req_valid && hit_w == '0) |=> (route_unsupported && !route_valid))
        else $error("request with no BAR hit was not flagged unsupported");
    chk_disabled_no_hit: assert property (@(posedge mclk) disable iff (!rstn)
        !(|(hit_w & ~bar_enable)))
        else $error("disabled BAR decoded a request");
    chk_shadow_no_hit: assert property (@(posedge mclk) disable iff (!rstn)
        !(|(hit_w & shadowed)))
        else $error("upper half of 64-bit BAR decoded a request");
    chk_bar0_dma: assert property (@(posedge mclk) disable iff (!rstn)
        (req_valid && hit_w[0] && !bar0_mailbox) |=> (route_target == PBM_TGT_DMA && route_bar == 3'h0))
        else $error("BAR0 hit not routed to DMA");
    chk_mbox_no_dma: assert property (@(posedge mclk) disable iff (!rstn)
        (req_valid && hit_w[0] && bar0_mailbox && req_is_dma) |=> (route_rejected && !route_valid))
        else $error("mailbox BAR forwarded a DMA request");
    chk_rp_two_bars: assert property (@(posedge mclk) disable iff (!rstn)
        root_port_mode |-> (hit_w[NB-1:RP_BARS] == '0))
        else $error("root port decoded beyond two BARs");
    chk_gap_non_ari: assert property (@(posedge mclk) disable iff (!rstn)
        (!ari_enable) |=> (general_first_vf_gap == GAP_NON_ARI))
        else $error("non-ARI first VF gap not forced to one");
    chk_pf1_gap: assert property (@(posedge mclk) disable iff (!rstn)
        (pf_vf_count[VF_CNT_W +: VF_CNT_W] != '0) |=>
        (per_pf_first_vf_gap[15:8] == 8'(VF_BASE_NUM - PF1_FUNC_NUM + $past(pf0_cnt))))
        else $error("second PF first VF gap wrong");
    chk_vf_reset_off: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(rstn) |-> (vf_active == '0))
        else $error("virtual functions active after reset");
    chk_total_limit: assert property (@(posedge mclk) disable iff (!rstn)
        (vf_total > 10'(TOTAL_VF_MAX)) |=> vf_config_error)
        else $error("VF total above limit not flagged");
endmodule : pbm_function_map
`default_nettype wire

// *** sim/pbm_host_model.sv ***
// Host model: issues routed requests and enables VFs
`timescale 1ns/1ps
`default_nettype none
module pbm_host_model
(
    // Clock
    input wire logic mclk,
    // Requests and VF enable
    output logic req_valid,
    output logic [63:0] req_addr,
    output logic req_is_dma,
    output logic [3:0] vf_enable_wr,
    output logic [3:0] vf_enable_val
);
    // Idle values at time zero
    initial
    begin
        req_valid = 1'b0;
        req_addr = 64'h0;
        req_is_dma = 1'b0;
        vf_enable_wr = 4'h0;
        vf_enable_val = 4'h0;
    end
    // One request over one rising edge; idle lines invert so stale data never matches
    task automatic request(input logic [63:0] a, input logic d);
        req_valid = 1'b1;
        req_addr = a;
        req_is_dma = d;
        @(negedge mclk);
        req_valid = 1'b0;
        req_addr = ~a;
        req_is_dma = ~d;
    endtask : request
    // Software enables VFs only after reading the capability fields
    task automatic enable_vfs(input logic [3:0] v);
        vf_enable_wr = 4'hf;
        vf_enable_val = v;
        @(negedge mclk);
        vf_enable_wr = 4'h0;
        vf_enable_val = ~v;
    endtask : enable_vfs
endmodule : pbm_host_model
`default_nettype wire

// *** sim/pcie_bar_and_vf_function_map_tb.sv ***
// Self-checking bench for the BAR router and VF function map
`timescale 1ns/1ps
`default_nettype none
module pcie_bar_and_vf_function_map_tb;
    import pbm_pkg::*;
    logic mclk, rstn, root_port_mode, bar0_mailbox, ari_enable, gap_sel_large;
    logic [5:0] bar_enable, bar_is64, bar_to_bridge;
    logic [35:0] bar_size_log2;
    logic [383:0] bar_base, bar_xlate;
    logic req_valid, req_is_dma, route_valid, route_unsupported, route_rejected, vf_config_error;
    logic [63:0] req_addr, route_axi_addr, a, pf_dep_link, pf_vf_dev_id, per_pf_dep_link, per_pf_vf_dev_id;
    logic [2:0] route_target, route_bar;
    logic [31:0] pf_vf_count, per_pf_first_vf_gap, per_pf_total_vfs, rs;
    logic [15:0] pf_cap_version, per_pf_cap_version;
    logic [127:0] pf_page_sizes, per_pf_page_sizes;
    logic [3:0] vf_enable_wr, vf_enable_val, vf_active;
    logic [7:0] general_first_vf_gap;
    logic [2:0] tgt [6] = '{PBM_TGT_DMA, PBM_TGT_LITE, PBM_TGT_BRIDGE, PBM_TGT_LITE, PBM_TGT_BRIDGE, PBM_TGT_NONE};
    int mismatches, checks_done, lg;
    pbm_function_map DUT (.mclk, .rstn, .root_port_mode, .bar_enable, .bar_is64, .bar_to_bridge, .bar0_mailbox,
        .bar_size_log2, .bar_base, .bar_xlate, .req_valid, .req_addr, .req_is_dma, .route_valid, .route_target,
        .route_bar, .route_axi_addr, .route_unsupported, .route_rejected, .ari_enable, .gap_sel_large, .pf_vf_count,
        .pf_cap_version, .pf_dep_link, .pf_vf_dev_id, .pf_page_sizes, .vf_enable_wr, .vf_enable_val,
        .general_first_vf_gap, .per_pf_first_vf_gap, .per_pf_total_vfs, .per_pf_cap_version, .per_pf_dep_link,
        .per_pf_vf_dev_id, .per_pf_page_sizes, .vf_active, .vf_config_error);
    pbm_host_model host (.mclk, .req_valid, .req_addr, .req_is_dma, .vf_enable_wr, .vf_enable_val);
    // 100 ns clock
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Xorshift keeps the stimulus repeatable
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : rnd
    // Offset bits from the request, upper bits from the translation
    function automatic logic [63:0] exp_axi(input logic [63:0] ad, input logic [63:0] xl, input int n);
        logic [63:0] m;
        m = (64'h1 << n) - 64'h1;
        return (ad & m) | (xl & ~m);
    endfunction : exp_axi
    task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic setbar(input int i, input logic en, input int n, input logic [63:0] b, input logic br);
        bar_enable[i] = en;
        bar_size_log2[i*6 +: 6] = 6'(n);
        bar_base[i*64 +: 64] = b;
        bar_to_bridge[i] = br;
        bar_xlate[i*64 +: 64] = {rnd(), rnd()};
    endtask : setbar
    // One request, answer looked at in the cycle it stands
    task automatic send(input logic [63:0] ad, input logic d, input logic [2:0] t, input logic [2:0] b,
        input logic u, input logic rj);
        host.request(ad, d);
        check("route_valid", route_valid, !u && !rj);
        check("route_target", route_target, t);
        check("route_unsupported", route_unsupported, u);
        check("route_rejected", route_rejected, rj);
        if (!u && !rj)
            check("route_bar", route_bar, b);
        if (t == PBM_TGT_LITE || t == PBM_TGT_BRIDGE)
            check("route_axi_addr", route_axi_addr, exp_axi(ad, bar_xlate[b*64 +: 64], lg));
        @(negedge mclk);
    endtask : send
    // New SR-IOV settings, then the capability fields two cycles later
    task automatic sriov(input logic ar, input logic lrg, input logic [31:0] c, input logic [7:0] g,
        input logic cp, input logic [31:0] pg, input logic e);
        ari_enable = ar;
        gap_sel_large = lrg;
        pf_vf_count = c;
        pf_cap_version = 16'(rnd());
        pf_dep_link = {rnd(), rnd()};
        pf_vf_dev_id = {rnd(), rnd()};
        pf_page_sizes = {rnd(), rnd(), rnd(), rnd()};
        repeat (2) @(negedge mclk);
        check("general_first_vf_gap", general_first_vf_gap, g);
        if (cp)
            check("per_pf_first_vf_gap", per_pf_first_vf_gap, pg);
        check("per_pf_total_vfs", per_pf_total_vfs, c);
        check("per_pf_cap_version", per_pf_cap_version, pf_cap_version);
        check("per_pf_dep_link", per_pf_dep_link, pf_dep_link);
        check("per_pf_vf_dev_id", per_pf_vf_dev_id, pf_vf_dev_id);
        check("per_pf_page_sizes", per_pf_page_sizes, pf_page_sizes);
        check("vf_config_error", vf_config_error, e);
    endtask : sriov
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // Watchdog well beyond the hundred or so cycles the tests need
    initial
    begin
        repeat (3000) @(posedge mclk);
        mismatches++;
        conclude();
    end
    // Main sequence
    initial
    begin
        {rs, mismatches, checks_done, rstn, root_port_mode, bar0_mailbox, ari_enable, gap_sel_large} = {32'ha03c, 69'h0};
        {bar_is64, pf_vf_count, pf_cap_version, pf_dep_link, pf_vf_dev_id, pf_page_sizes} = '0;
        for (int i = 0; i < 6; i++)
            setbar(i, i < 5, i == 1 ? 20 : 17, 64'(i + 1) << 28, i == 4);
        repeat (6) @(negedge mclk);
        rstn = 1'b1;
        check("vf_active", vf_active, 4'h0);
        // Every window at offset zero, top offset and random offsets; BAR5 disabled
        for (int i = 0; i < 6; i++)
            for (int k = 0; k < 4; k++)
            begin
                lg = i == 1 ? 20 : 17;
                a = k == 0 ? 64'h0 : (k == 1 ? 64'hffffffff : 64'(rnd()));
                send((64'(i + 1) << 28) + (a & ((64'h1 << lg) - 64'h1)), 1'b0, tgt[i], 3'(i), i == 5, 1'b0);
            end
        send(64'h08000000, 1'b0, PBM_TGT_NONE, 3'h0, 1'b1, 1'b0);
        $display("test routing done");
        // Mailbox BAR0 refuses DMA and space below the mailbox area
        bar0_mailbox = 1'b1;
        send(64'h10002400, 1'b1, PBM_TGT_NONE, 3'h0, 1'b0, 1'b1);
        send(64'h100023ff, 1'b0, PBM_TGT_NONE, 3'h0, 1'b0, 1'b1);
        send(64'h10002400, 1'b0, PBM_TGT_MBOX, 3'h0, 1'b0, 1'b0);
        bar0_mailbox = 1'b0;
        root_port_mode = 1'b1;
        send(64'h30000000, 1'b0, PBM_TGT_NONE, 3'h0, 1'b1, 1'b0);
        lg = 20;
        send(64'h20000010, 1'b0, PBM_TGT_LITE, 3'h1, 1'b0, 1'b0);
        root_port_mode = 1'b0;
        $display("test mailbox and root port done");
        // 64-bit BAR2 shadows BAR3; undersized BAR1 clamps to 128 bytes
        bar_is64[2] = 1'b1;
        setbar(2, 1'b1, 40, 64'h10000000000, 1'b1);
        setbar(1, 1'b1, 3, 64'h20000000, 1'b0);
        lg = 40;
        send(64'h11234567890, 1'b0, PBM_TGT_BRIDGE, 3'h2, 1'b0, 1'b0);
        send(64'h40000000, 1'b0, PBM_TGT_NONE, 3'h0, 1'b1, 1'b0);
        lg = 7;
        send(64'h2000007f, 1'b0, PBM_TGT_LITE, 3'h1, 1'b0, 1'b0);
        send(64'h20000080, 1'b0, PBM_TGT_NONE, 3'h0, 1'b1, 1'b0);
        // An odd BAR flagged 64-bit is no window at all
        bar_is64[1] = 1'b1;
        send(64'h20000000, 1'b0, PBM_TGT_NONE, 3'h0, 1'b1, 1'b0);
        $display("test apertures done");
        // VF numbering, legal and illegal splits, ARI on and off
        sriov(1'b1, 1'b1, 32'h00000302, 8'h40, 1'b1, 32'h00004140, 1'b0);
        host.enable_vfs(4'hf);
        check("vf_active", vf_active, 4'h3);
        sriov(1'b1, 1'b0, 32'h000000fc, 8'h04, 1'b0, 32'h0, 1'b0);
        sriov(1'b1, 1'b0, 32'h000001fc, 8'h04, 1'b0, 32'h0, 1'b1);
        host.enable_vfs(4'hf);
        check("vf_active", vf_active, 4'h0);
        sriov(1'b1, 1'b1, 32'h000000fc, 8'h40, 1'b0, 32'h0, 1'b1);
        sriov(1'b0, 1'b1, 32'h00000007, 8'h01, 1'b0, 32'h0, 1'b0);
        sriov(1'b0, 1'b1, 32'h00000107, 8'h01, 1'b0, 32'h0, 1'b1);
        $display("test function map done");
        conclude();
    end
endmodule : pcie_bar_and_vf_function_map_tb
`default_nettype wire
